// ==== design/asa_alarm_status_aggregator.sv ====
/*
 Alarm status aggregator: sticky write-1-to-clear alarm flags, mask,
 summary bit, pin routing and an event interrupt, behind AXI4-Lite.
 Assumes alarm condition inputs are synchronous to clk; soft_reset
 is a one-cycle pulse from elsewhere in the device.
*/
// The AXI4-Lite interface to the registers was left to the implementer.
// Notes on behaviour
// RL1: The summary bit is 1 whenever a flag is set and its mask bit is clear, else 0.
// RL2: A control bit routes the summary bit onto the calibration-status pin as an interrupt.
// RL3: Status resets to 0x3F and each flag in bits 5..0 clears when software writes 1 to it.
// RL4: The FIFO flag, bit 5, sets when any active lane FIFO overflows or underflows.
// RL5: The serializer PLL flag, bit 4, sets whenever that PLL is not locked.
// RL6: In 8b/10b modes the link flag, bit 3, sets while the link is enabled and not in data state.
// RL7: In 64b/66b modes the link flag sets at first link startup and on any forced realignment.
// RL8: The realignment flag, bit 2, sets whenever a SYSREF event realigns the internal clocks.
// RL9: The clock flag, bit 0, sets whenever the two channel groups' clock dividers disagree.
// RL10: After power-on or soft reset every alarm flag starts at 1.
// RL11: With the link disabled all flags but the clock flag are undefined; software clears them after enabling.
// RL12: Each alarm has a mask bit, reset set, and a set mask keeps its flag out of the summary.
// RL13: Per-lane FIFO flags clear by writing 1, and writing 1 to the FIFO status flag clears them all.
// RL14: Writing 0 leaves a flag alone, and a condition that persists sets the flag again at once.
`timescale 1ns/1ns
`default_nettype none
module asa_alarm_status_aggregator
   import asa_pkg::*;
#(
   parameter int LANES = 8
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic                  clk_en,
   input  wire logic                  soft_reset,
   // Alarm conditions
   input  wire logic [LANES-1:0]      lane_active,
   input  wire logic [LANES-1:0]      lane_fifo_err,
   input  wire logic                  spll_locked,
   input  wire logic                  link_data_state,
   input  wire logic                  link_realign,
   input  wire logic                  sysref_realign,
   input  wire logic                  divider_mismatch,
   // Pins
   output logic                       cal_status_pin,
   input  wire logic                  cal_done,
   output logic                       serial_link_enable,
   output logic                       irq,
   // AXI4-Lite
   input  wire logic [ASA_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [ASA_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);

   // Lane registers are one byte wide
   if (LANES < 1 || LANES > 8) begin : g_lanes_check
      $error("LANES must be 1..8");
   end

   function automatic logic [11:0] word_idx(input logic [ASA_ADDR_W-1:0] a);
      word_idx = a[ASA_ADDR_W-1:2];
   endfunction

   function automatic logic idx_known(input logic [11:0] i);
      idx_known = (i == ASA_IDX_SUMMARY) || (i == ASA_IDX_STATUS) || (i == ASA_IDX_MASK) ||
                  (i == ASA_IDX_LANE) || (i == ASA_IDX_CTRL) || (i == ASA_IDX_IRQ_STAT) ||
                  (i == ASA_IDX_IRQ_EN) || (i == ASA_IDX_IRQ_CLR);
   endfunction

   // Write channel capture
   logic                  aw_hold_q;
   logic                  w_hold_q;
   logic [ASA_ADDR_W-1:0] awaddr_q;
   logic [7:0]            wdata_q;
   logic                  wstrb0_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   logic                  wr_fire;
   logic [11:0]           wr_idx;
   logic [7:0]            wr_ones;

   assign s_axi_awready = !aw_hold_q && !bvalid_q;
   assign s_axi_wready  = !w_hold_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign wr_fire       = clk_en && aw_hold_q && w_hold_q && !bvalid_q;
   assign wr_idx        = word_idx(awaddr_q);
   // Only lane 0 carries the 8-bit register; other lanes ignored
   assign wr_ones       = wstrb0_q ? wdata_q : 8'h00;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_hold_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         w_hold_q <= 1'b0;
         wdata_q  <= 8'h00;
         wstrb0_q <= 1'b0;
      end else if (clk_en) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_hold_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bvalid_q <= 1'b0;
         bresp_q  <= ASA_RESP_OKAY;
      end else if (clk_en) begin
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= idx_known(wr_idx) ? ASA_RESP_OKAY : ASA_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   logic wr_status;
   logic wr_mask;
   logic wr_lane;
   logic wr_ctrl;
   logic wr_irq_en;
   logic wr_irq_clr;
   assign wr_status  = wr_fire && (wr_idx == ASA_IDX_STATUS);
   assign wr_mask    = wr_fire && (wr_idx == ASA_IDX_MASK) && wstrb0_q;
   assign wr_lane    = wr_fire && (wr_idx == ASA_IDX_LANE);
   assign wr_ctrl    = wr_fire && (wr_idx == ASA_IDX_CTRL) && wstrb0_q;
   assign wr_irq_en  = wr_fire && (wr_idx == ASA_IDX_IRQ_EN) && wstrb0_q;
   assign wr_irq_clr = wr_fire && (wr_idx == ASA_IDX_IRQ_CLR);

   // Control: link enable, 64b/66b mode, pin select
   logic [2:0] ctrl_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= ASA_CTRL_RST;
      end else if (clk_en) begin
         if (soft_reset) begin
            ctrl_q <= ASA_CTRL_RST;
         end else if (wr_ctrl) begin
            ctrl_q <= wdata_q[2:0];
         end
      end
   end
   assign serial_link_enable = ctrl_q[ASA_CTRL_LINK_EN];

   // 64b/66b start-up: a rising link enable counts as a realignment
   logic link_en_prev_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         link_en_prev_q <= 1'b0;
      end else if (clk_en) begin
         link_en_prev_q <= serial_link_enable;
      end
   end

   // Condition vector in status-bit layout
   logic [7:0] cond;
   logic       link_cond;
   logic [LANES-1:0] lane_err;
   // RL4: active lanes only
   assign lane_err = lane_fifo_err & lane_active;
   always_comb begin
      if (ctrl_q[ASA_CTRL_ENC64]) begin
         // RL7: startup or realignment
         link_cond = serial_link_enable && ((!link_en_prev_q) || link_realign);
      end else begin
         // RL6: enabled but not in data state
         link_cond = serial_link_enable && !link_data_state;
      end
   end
   always_comb begin
      cond                = 8'h00;
      cond[ASA_BIT_FIFO]  = |lane_err;
      // RL5: PLL unlocked
      cond[ASA_BIT_SPLL]  = !spll_locked;
      cond[ASA_BIT_LINK]  = link_cond;
      // RL8: SYSREF realignment
      cond[ASA_BIT_REALN] = sysref_realign;
      // RL9: divider mismatch
      cond[ASA_BIT_CLK]   = divider_mismatch;
   end

   // Status flags; set wins over a clearing write
   logic [7:0] status_q;
   logic [7:0] status_clr;
   // RL3: write-one clears; RL14: zeros ignored
   assign status_clr = wr_status ? (wr_ones & ASA_FLAG_MASK) : 8'h00;
   // RL11: flags undefined while link off; logic keeps running, software clears after enable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // RL10: all flags start set
         status_q <= ASA_STATUS_RST;
      end else if (clk_en) begin
         if (soft_reset) begin
            status_q <= ASA_STATUS_RST;
         end else begin
            // RL14: persisting condition re-sets
            status_q <= ((status_q & ~status_clr) | cond) & ASA_FLAG_MASK;
         end
      end
   end

   // Per-lane FIFO flags
   logic [LANES-1:0] lane_q;
   logic [LANES-1:0] lane_clr;
   always_comb begin
      lane_clr = '0;
      if (wr_lane) begin
         lane_clr = wr_ones[LANES-1:0];
      end
      // RL13: status FIFO clear wipes all lanes
      if (status_clr[ASA_BIT_FIFO]) begin
         lane_clr = '1;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lane_q <= ASA_LANE_RST[LANES-1:0];
      end else if (clk_en) begin
         if (soft_reset) begin
            lane_q <= ASA_LANE_RST[LANES-1:0];
         end else begin
            // RL13: per-lane sticky
            lane_q <= (lane_q & ~lane_clr) | lane_err;
         end
      end
   end

   // Mask register, all bits stored as written
   logic [7:0] mask_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_q <= ASA_MASK_RST;
      end else if (clk_en) begin
         if (soft_reset) begin
            mask_q <= ASA_MASK_RST;
         end else if (wr_mask) begin
            mask_q <= wdata_q;
         end
      end
   end

   // RL12: masked flags excluded; RL1: summary of unmasked flags
   logic summary;
   assign summary = |(status_q & ~mask_q & ASA_FLAG_MASK);

   // RL2: pin shows summary when selected, else calibration status
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cal_status_pin <= 1'b0;
      end else if (clk_en) begin
         cal_status_pin <= ctrl_q[ASA_CTRL_PINSEL] ? summary : cal_done;
      end
   end

   // Interrupt events: summary rising, any flag newly set
   logic       summary_prev_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_en_q;
   logic [1:0] irq_evt;
   logic [1:0] irq_clr;
   assign irq_evt[ASA_IRQ_SUMMARY_RISE] = summary && !summary_prev_q;
   assign irq_evt[ASA_IRQ_FLAG_SET]     = |(cond & ~status_q & ASA_FLAG_MASK);
   assign irq_clr = wr_irq_clr ? wr_ones[1:0] : 2'b00;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         summary_prev_q <= 1'b0;
         irq_stat_q     <= 2'b00;
      end else if (clk_en) begin
         summary_prev_q <= summary;
         irq_stat_q     <= (irq_stat_q & ~irq_clr) | irq_evt;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_en_q <= 2'b00;
      end else if (clk_en && wr_irq_en) begin
         irq_en_q <= wdata_q[1:0];
      end
   end
   assign irq = |(irq_stat_q & irq_en_q);

   // Read channel
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [11:0] rd_idx;
   logic [7:0]  rd_val;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign rd_idx        = word_idx(s_axi_araddr);
   always_comb begin
      rd_val = 8'h00;
      if (rd_idx == ASA_IDX_SUMMARY) begin
         rd_val = {7'h00, summary};
      end else if (rd_idx == ASA_IDX_STATUS) begin
         rd_val = status_q;
      end else if (rd_idx == ASA_IDX_MASK) begin
         rd_val = mask_q;
      end else if (rd_idx == ASA_IDX_LANE) begin
         rd_val[LANES-1:0] = lane_q;
      end else if (rd_idx == ASA_IDX_CTRL) begin
         rd_val = {5'h00, ctrl_q};
      end else if (rd_idx == ASA_IDX_IRQ_STAT) begin
         rd_val = {6'h00, irq_stat_q};
      end else if (rd_idx == ASA_IDX_IRQ_EN) begin
         rd_val = {6'h00, irq_en_q};
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= ASA_RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_val};
            rresp_q  <= idx_known(rd_idx) ? ASA_RESP_OKAY : ASA_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ==== design/asa_pkg.sv ====
/*
 Package for the alarm status aggregator: register offsets, field
 positions and reset values.
 Assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
*/
package asa_pkg;
   // Printed offsets are not all multiples of four: kept as indices
   localparam logic [11:0] ASA_IDX_SUMMARY  = 12'h02c0;
   localparam logic [11:0] ASA_IDX_STATUS   = 12'h02c1;
   localparam logic [11:0] ASA_IDX_MASK     = 12'h02c2;
   localparam logic [11:0] ASA_IDX_LANE     = 12'h02c4;
   localparam logic [11:0] ASA_IDX_CTRL     = 12'h02c8;
   localparam logic [11:0] ASA_IDX_IRQ_STAT = 12'h02c9;
   localparam logic [11:0] ASA_IDX_IRQ_EN   = 12'h02ca;
   localparam logic [11:0] ASA_IDX_IRQ_CLR  = 12'h02cb;
   localparam int          ASA_ADDR_W       = 14;

   localparam int ASA_BIT_FIFO  = 5;
   localparam int ASA_BIT_SPLL  = 4;
   localparam int ASA_BIT_LINK  = 3;
   localparam int ASA_BIT_REALN = 2;
   localparam int ASA_BIT_RSVD1 = 1;
   localparam int ASA_BIT_CLK   = 0;

   localparam int ASA_CTRL_LINK_EN = 0;
   localparam int ASA_CTRL_ENC64   = 1;
   localparam int ASA_CTRL_PINSEL  = 2;

   localparam int ASA_IRQ_SUMMARY_RISE = 0;
   localparam int ASA_IRQ_FLAG_SET     = 1;

   localparam logic [7:0] ASA_STATUS_RST = 8'h3f;
   localparam logic [7:0] ASA_MASK_RST   = 8'h3f;
   localparam logic [7:0] ASA_LANE_RST   = 8'hff;
   localparam logic [7:0] ASA_FLAG_MASK  = 8'h3f;
   localparam logic [2:0] ASA_CTRL_RST   = 3'h0;

   localparam logic [1:0] ASA_RESP_OKAY   = 2'h0;
   localparam logic [1:0] ASA_RESP_SLVERR = 2'h2;
endpackage

// ==== bench/asa_checker.sv ====
/*
 Port checker for the alarm status aggregator.
 Assumes one clock, rst_b asynchronous active low, bound from the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module asa_checker
   import asa_pkg::*;
#(
   parameter int LANES = 8
) (
   // Clock, reset and conditions
   input wire logic                  clk,
   input wire logic                  rst_b,
   input wire logic                  clk_en,
   input wire logic                  spll_locked,
   input wire logic                  divider_mismatch,
   // Register bus
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic [ASA_ADDR_W-1:0] s_axi_araddr,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic [31:0]           s_axi_rdata,
   input wire logic [1:0]            s_axi_rresp,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready
);
   localparam logic [ASA_ADDR_W-1:0] ST_A = {ASA_IDX_STATUS, 2'b00};
   localparam logic [ASA_ADDR_W-1:0] UNM_A = 14'h0b0c;
   logic ar_hs;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   assign ar_hs = s_axi_arvalid && s_axi_arready && clk_en;

   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped before bready");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed before rready");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready high while rvalid");
   a_read_lat: assert property (ar_hs |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en
      |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_spll_flag: assert property (!spll_locked && clk_en ##1 ar_hs && s_axi_araddr == ST_A
      |=> s_axi_rdata[ASA_BIT_SPLL]) else $error("pll flag not set");
   a_clk_flag: assert property (divider_mismatch && clk_en ##1 ar_hs && s_axi_araddr == ST_A
      |=> s_axi_rdata[ASA_BIT_CLK]) else $error("clock flag not set");
   a_unmapped_err: assert property (ar_hs && s_axi_araddr == UNM_A
      |=> s_axi_rresp == ASA_RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
endmodule
`default_nettype wire

// ==== bench/asa_host_model.sv ====
/*
 Host interrupt input: counts rising edges of the interrupt line.
 Assumes irq is synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module asa_host_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Interrupt line
   input  wire logic irq,
   output var int    rises
);
   logic irq_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
         rises <= 0;
      end else begin
         irq_q <= irq;
         if (irq && !irq_q)
            rises <= rises + 1;
      end
   end
endmodule
`default_nettype wire

// ==== bench/tb_asa_alarm_status_aggregator.sv ====
/*
 Bench for the alarm status aggregator: register tasks over AXI4-Lite.
 Assumes byte address is four times the register index.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_asa_alarm_status_aggregator
   import asa_pkg::*;
;
   logic                  clk, rst_b, clk_en, soft_reset, spll_locked, link_data_state, link_realign;
   logic                  sysref_realign, divider_mismatch, cal_status_pin, cal_done, serial_link_enable, irq;
   logic [7:0]            lane_active, lane_fifo_err;
   logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [ASA_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]           s_axi_wdata, s_axi_rdata;
   logic [3:0]            s_axi_wstrb;
   logic [1:0]            s_axi_bresp, s_axi_rresp, wresp, rresp;
   int                    err_total, compares, cycles, irq_rises, n0;

   asa_alarm_status_aggregator #(.LANES(8)) asa_alarm_status_aggregator_inst (.clk, .rst_b, .clk_en,
      .soft_reset, .lane_active, .lane_fifo_err, .spll_locked, .link_data_state, .link_realign,
      .sysref_realign, .divider_mismatch, .cal_status_pin, .cal_done, .serial_link_enable, .irq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   asa_host_model asa_host_model_inst (.clk, .rst_b, .irq, .rises(irq_rises));

   always #20 clk = ~clk;

   task automatic test_done();
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Whole run needs well under 2000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         test_done();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Response ready raised with the request; a leading edge keeps calls apart
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      logic da = 1'b0;
      logic dw = 1'b0;
      @(posedge clk);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(da && dw)) begin
         @(negedge clk);
         da = da || s_axi_awready;
         dw = dw || s_axi_wready;
         @(posedge clk);
         if (da)
            s_axi_awvalid <= 1'b0;
         if (dw)
            s_axi_wvalid <= 1'b0;
      end
      do @(negedge clk); while (!s_axi_bvalid);
      @(posedge clk);
      wresp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rc(input logic [11:0] idx, input logic [31:0] exp);
      @(posedge clk);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(negedge clk); while (!s_axi_arready);
      @(posedge clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk); while (!s_axi_rvalid);
      @(posedge clk);
      rresp = s_axi_rresp;
      chk($sformatf("reg %h", idx), exp, s_axi_rdata);
      s_axi_rready <= 1'b0;
   endtask

   task automatic cond(input int b, input logic v);
      @(posedge clk);
      case (b)
         5: lane_fifo_err <= v ? 8'h01 : 8'h00;
         4: spll_locked <= !v;
         3: link_data_state <= !v;
         2: sysref_realign <= v;
         default: divider_mismatch <= v;
      endcase
   endtask

   initial begin
      int bits[5] = '{5, 4, 3, 2, 0};
      {clk, rst_b, soft_reset, link_realign, sysref_realign, divider_mismatch, cal_done} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {clk_en, spll_locked, link_data_state} = 3'h7;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'h1;
      lane_active = 8'h01;
      lane_fifo_err = 8'h00;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rc(ASA_IDX_STATUS, 32'h0000_003f);
      rc(ASA_IDX_MASK, 32'h0000_003f);
      rc(ASA_IDX_SUMMARY, 32'h0000_0000);
      rc(ASA_IDX_LANE, 32'h0000_00ff);
      wr(ASA_IDX_CTRL, 8'h01);
      wr(ASA_IDX_STATUS, 8'h3f);
      rc(ASA_IDX_STATUS, 32'h0000_0000);
      rc(ASA_IDX_LANE, 32'h0000_0000);
      wr(ASA_IDX_IRQ_EN, 8'h01);
      n0 = irq_rises;
      foreach (bits[i]) begin
         wr(ASA_IDX_MASK, 8'h01 << bits[i]);
         cond(bits[i], 1'b1);
         cond(bits[i], 1'b0);
         rc(ASA_IDX_STATUS, 32'h1 << bits[i]);
         rc(ASA_IDX_SUMMARY, 32'h0000_0000);
         wr(ASA_IDX_MASK, 8'h00);
         rc(ASA_IDX_SUMMARY, 32'h0000_0001);
         chk("irq", 1, irq);
         rc(ASA_IDX_IRQ_STAT, 32'h0000_0003);
         wr(ASA_IDX_IRQ_CLR, 8'h03);
         chk("irq", 0, irq);
         wr(ASA_IDX_STATUS, 8'h00);
         rc(ASA_IDX_STATUS, 32'h1 << bits[i]);
         if (bits[i] == 5)
            rc(ASA_IDX_LANE, 32'h0000_0001);
         wr(ASA_IDX_STATUS, 8'h01 << bits[i]);
         rc(ASA_IDX_STATUS, 32'h0000_0000);
         rc(ASA_IDX_LANE, 32'h0000_0000);
         rc(ASA_IDX_SUMMARY, 32'h0000_0000);
      end
      chk("irq rises", 5, irq_rises - n0);
      wr(ASA_IDX_IRQ_EN, 8'h00);
      cond(4, 1'b1);
      wr(ASA_IDX_STATUS, 8'h10);
      rc(ASA_IDX_STATUS, 32'h0000_0010);
      cond(4, 1'b0);
      lane_active <= 8'h00;
      lane_fifo_err <= 8'h02;
      wr(ASA_IDX_STATUS, 8'h10);
      rc(ASA_IDX_STATUS, 32'h0000_0000);
      lane_fifo_err <= 8'h00;
      wr(ASA_IDX_CTRL, 8'h00);
      wr(ASA_IDX_CTRL, 8'h03);
      chk("link enable", 1, serial_link_enable);
      rc(ASA_IDX_STATUS, 32'h0000_0008);
      wr(ASA_IDX_STATUS, 8'h08);
      @(posedge clk);
      link_realign <= 1'b1;
      @(posedge clk);
      link_realign <= 1'b0;
      rc(ASA_IDX_STATUS, 32'h0000_0008);
      wr(ASA_IDX_STATUS, 8'h08);
      wr(ASA_IDX_CTRL, 8'h05);
      cal_done <= 1'b1;
      // Pin is registered and now selects the summary: let it settle, then check that cal_done is not on it
      repeat (2) @(negedge clk);
      chk("pin", 0, cal_status_pin);
      cond(0, 1'b1);
      cond(0, 1'b0);
      repeat (2) @(negedge clk);
      chk("pin", 1, cal_status_pin);
      wr(ASA_IDX_STATUS, 8'h01);
      wr(ASA_IDX_CTRL, 8'h01);
      @(negedge clk);
      chk("pin", 1, cal_status_pin);
      cond(0, 1'b1);
      rc(ASA_IDX_STATUS, 32'h0000_0001);
      cond(0, 1'b0);
      // Frozen clock enable must swallow a realignment pulse
      @(posedge clk);
      clk_en <= 1'b0;
      sysref_realign <= 1'b1;
      @(posedge clk);
      clk_en <= 1'b1;
      sysref_realign <= 1'b0;
      rc(ASA_IDX_STATUS, 32'h0000_0001);
      wr(12'h2c3, 8'hff);
      chk("bresp", ASA_RESP_SLVERR, wresp);
      rc(12'h2c3, 32'h0000_0000);
      chk("rresp", ASA_RESP_SLVERR, rresp);
      @(posedge clk);
      soft_reset <= 1'b1;
      @(posedge clk);
      soft_reset <= 1'b0;
      rc(ASA_IDX_STATUS, 32'h0000_003f);
      rc(ASA_IDX_MASK, 32'h0000_003f);
      test_done();
   end
endmodule

bind asa_alarm_status_aggregator asa_checker #(.LANES(LANES)) asa_checker_inst (.clk, .rst_b, .clk_en,
   .spll_locked, .divider_mismatch, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
